//--- core/sfw_pkg.sv
package sfw_pkg;

  // Nibble and address widths
  localparam int unsigned SFW_NIB_W   = 4;
  localparam int unsigned SFW_SYS_W   = 7;
  localparam int unsigned SFW_DM_W    = 11;

  // System register addresses inside a row/column space
  localparam logic [6:0] SFW_ADDR_BANK  = 7'h7D;
  localparam logic [6:0] SFW_ADDR_ROW   = 7'h7E;
  localparam logic [6:0] SFW_ADDR_FLAGS = 7'h7F;

  // Bit positions of the flag word
  localparam int unsigned SFW_BIT_DEC  = 0;  // In row nibble
  localparam int unsigned SFW_BIT_CMP  = 3;
  localparam int unsigned SFW_BIT_CY   = 2;
  localparam int unsigned SFW_BIT_ZERO = 1;
  localparam int unsigned SFW_BIT_IXE  = 0;

  // Reset values
  localparam logic [3:0] SFW_RST_BANK  = 4'h0;
  localparam logic [3:0] SFW_RST_ROW   = 4'h0;
  localparam logic [3:0] SFW_RST_FLAGS = 4'h0;
  localparam logic [3:0] SFW_RST_DATA  = 4'h0;
  localparam logic [10:0] SFW_RST_ADDR = 11'h000;

  // Decimal adjust constants
  localparam logic [4:0] SFW_DEC_LIMIT = 5'h09;
  localparam logic [4:0] SFW_DEC_ADJ   = 5'h06;
  localparam logic [3:0] SFW_NIB_ZERO  = 4'h0;

  // Operations handed over by the instruction decoder
  typedef enum logic [2:0] {
    SFW_OP_NONE = 3'b000,
    SFW_OP_ADD  = 3'b001,
    SFW_OP_ADDC = 3'b010,
    SFW_OP_SUB  = 3'b011,
    SFW_OP_SUBC = 3'b100,
    SFW_OP_ROTATE_RIGHT_THROUGH_CARRY_OP = 3'b101,
    SFW_OP_PASS = 3'b110
  } sfw_op_t;

endpackage

//--- core/sfw_flags_core.sv
// Local design decision: the strobed register port.
`timescale 1ns/100ps
// Functional notes
// - Five-bit word from 7EH bit0, 7FH.
// - Decimal 7EH.0; compare, carry, zero, index in 7FH.
// - Index flag set modifies memory operand address.
// - Zero flag update depends on compare flag.
// - Zero result: compare clear sets zero; set retains zero.
// - Carry follows carry or borrow of add/sub.
// - Carry shifts through rotate-right instruction.
// - Compare flag set suppresses add/sub result write-back.
// - Decimal flag selects decimal arithmetic.
// - Arithmetic into 7FH stores result, not flags.
// - Working register is sixteen nibbles of one row.
// - Working row from pointer, not current bank.
// - Bank from 7DH, row from 7EH high bits.
// - Register operand gives only the column.
// - One instruction operates register with memory nibble.
// - Working register stays plain data memory.
module sfw_flags_core
  import sfw_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  // Register port
  input  wire logic [SFW_SYS_W-1:0]  regAddr,
  input  wire logic [SFW_NIB_W-1:0]  regWrData,
  input  wire logic                  regWrStrobe,
  input  wire logic                  regRdStrobe,
  output logic      [SFW_NIB_W-1:0]  regRdData,
  // Instruction step from the decoder
  input  wire logic                  instrEn,
  input  wire sfw_pkg::sfw_op_t      aluOp,
  input  wire logic [SFW_NIB_W-1:0]  memNibble,
  input  wire logic [SFW_NIB_W-1:0]  wrkNibble,
  input  wire logic [SFW_NIB_W-1:0]  opColumn,
  input  wire logic [SFW_DM_W-1:0]   memAddr,
  input  wire logic [SFW_DM_W-1:0]   indexValue,
  input  wire logic                  destIsWrk,
  // Flag word and working register address
  output logic [4:0]                 flagWord,
  output logic                       decimalMode,
  output logic                       indexModifyEnable,
  output logic [SFW_DM_W-1:0]        wrkAddr,
  output logic [SFW_DM_W-1:0]        effMemAddr,
  // Result write-back
  output logic                       resultWrite,
  output logic [SFW_DM_W-1:0]        resultAddr,
  output logic [SFW_NIB_W-1:0]       resultData
);

  typedef struct packed {
    // Working row pointer, bank then row
    logic [3:0]  bankNib;
    logic [3:0]  rowNib;
    // Compare, carry, zero and index bits
    logic [3:0]  flags;
    // Read data, standing one cycle
    logic [3:0]  rdData;
    // Operand addresses of the last step
    logic [10:0] wrkAddr;
    logic [10:0] effAddr;
    // Write-back request to data memory
    logic        resWr;
    logic [10:0] resAddr;
    logic [3:0]  resData;
  } sfw_state_t;

  sfw_state_t state_q;
  sfw_state_t state_d;

  // Working register address from the pointer and a column
  function automatic logic [10:0] sfw_wrk_addr(
    input logic [3:0] bank,
    input logic [3:0] row,
    input logic [3:0] col
  );
    // Row takes pointer bits 3..1; bit 0 is the decimal flag
    sfw_wrk_addr = {bank, row[3:1], col};
  endfunction

  // Register port address decode
  function automatic logic sfw_hit(
    input logic [6:0] addr,
    input logic [6:0] target
  );
    // Exact seven-bit match of a system address
    sfw_hit = (addr == target);
  endfunction

  // Sum or difference with carry out in bit 4
  logic [4:0] sumBin;
  // Decimal-adjusted sum or difference
  logic [4:0] sumDec;
  // Nibble result of the step
  logic [3:0] aluRes;
  // Carry or borrow produced by the step
  logic       aluCarry;

  // Carry fed into chained add or subtract
  logic       carryIn;
  // Add or subtract of any form
  logic       isArith;
  // Subtract of any form
  logic       isSub;
  // Result goes back to memory
  logic       doStore;

  // Compare flag as it stood before the step
  logic       cmpFlag;
  // Decimal flag as it stood before the step
  logic       decFlag;
  // Where the result lands
  logic [10:0] destAddr;

  // Binary or decimal add/subtract and rotate
  // Every variable defaulted first, so no latch
  always_comb begin
    // Flags as they stood before this step
    cmpFlag  = state_q.flags[SFW_BIT_CMP];
    decFlag  = state_q.rowNib[SFW_BIT_DEC];
    // Operation class decode
    isSub    = (aluOp == SFW_OP_SUB) || (aluOp == SFW_OP_SUBC);
    isArith  = (aluOp == SFW_OP_ADD) || (aluOp == SFW_OP_ADDC) || isSub;
    // Carry enters only for the chained forms
    carryIn  = ((aluOp == SFW_OP_ADDC) || (aluOp == SFW_OP_SUBC))
               ? state_q.flags[SFW_BIT_CY] : 1'b0;

    // Defaults: operand passes, carry holds
    sumBin   = 5'h00;
    sumDec   = 5'h00;
    aluRes   = wrkNibble;
    aluCarry = state_q.flags[SFW_BIT_CY];
    unique case (aluOp)
      SFW_OP_ADD, SFW_OP_ADDC: begin
        // Register and memory nibble added in one step
        sumBin = {1'b0, wrkNibble} + {1'b0, memNibble}
                 + {4'h0, carryIn};
        // Above nine: skip six codes and force carry
        if (decFlag && (sumBin > SFW_DEC_LIMIT)) begin
          sumDec   = sumBin + SFW_DEC_ADJ;
          aluRes   = sumDec[3:0];
          aluCarry = 1'b1;
        end else begin
          aluRes   = sumBin[3:0];
          aluCarry = sumBin[4];
        end
      end
      SFW_OP_SUB, SFW_OP_SUBC: begin
        // Borrow appears in bit 4 of the difference
        sumBin = {1'b0, wrkNibble} - {1'b0, memNibble}
                 - {4'h0, carryIn};
        // Decimal borrow pulls the digit back by six
        if (decFlag && sumBin[4]) begin
          sumDec = sumBin - SFW_DEC_ADJ;
          aluRes = sumDec[3:0];
        end else begin
          aluRes = sumBin[3:0];
        end
        aluCarry = sumBin[4];
      end
      SFW_OP_ROTATE_RIGHT_THROUGH_CARRY_OP: begin
        // Carry enters at the top, bit 0 leaves into carry
        aluRes   = {state_q.flags[SFW_BIT_CY], wrkNibble[3:1]};
        aluCarry = wrkNibble[0];
      end
      SFW_OP_PASS: begin
        // Transfer of the memory nibble, flags kept
        aluRes = memNibble;
      end
      SFW_OP_NONE: begin
        // Address step only, nothing stored
        aluRes = wrkNibble;
      end
      default: begin
        // Unused code passes the working nibble, which is still stored
        aluRes = wrkNibble;
      end
    endcase

    // Rotate always stores; arithmetic only with compare flag clear
    doStore  = (aluOp != SFW_OP_NONE) && !(isArith && cmpFlag);
    // Destination: working register or memory operand
    destAddr = destIsWrk ? state_q.wrkAddr : state_q.effAddr;
  end

  // Next-state logic
  // Order below sets priority: ALU first, software last
  always_comb begin
    state_d       = state_q;
    // Write-back pulse lasts one cycle only
    state_d.resWr = 1'b0;

    // Address generation each step
    if (instrEn) begin
      // Bank and row from the pointer, column from the operand
      state_d.wrkAddr = sfw_wrk_addr(state_q.bankNib, state_q.rowNib,
                                     opColumn);
      // Index flag steers memory operand modification
      state_d.effAddr = state_q.flags[SFW_BIT_IXE]
                        ? (memAddr + indexValue) : memAddr;
    end
    // Flag update and write-back of an executed operation
    if (instrEn && (aluOp != SFW_OP_NONE)) begin
      // Carry only from arithmetic and rotate
      if (isArith || (aluOp == SFW_OP_ROTATE_RIGHT_THROUGH_CARRY_OP)) begin
        state_d.flags[SFW_BIT_CY] = aluCarry;
      end
      if (isArith) begin
        // Nonzero result always clears zero
        if (aluRes != SFW_NIB_ZERO) begin
          state_d.flags[SFW_BIT_ZERO] = 1'b0;
        // Zero result sets it only without compare
        end else if (!cmpFlag) begin
          state_d.flags[SFW_BIT_ZERO] = 1'b1;
        end
      end
      if (doStore) begin
        // Working register row is ordinary data memory
        state_d.resWr   = 1'b1;
        state_d.resAddr = destAddr;
        state_d.resData = aluRes;
        // Result landing on a system register loads it too
        if (sfw_hit(destAddr[6:0], SFW_ADDR_FLAGS)) begin
          state_d.flags = aluRes;
        end else if (sfw_hit(destAddr[6:0], SFW_ADDR_ROW)) begin
          state_d.rowNib = aluRes;
        end else if (sfw_hit(destAddr[6:0], SFW_ADDR_BANK)) begin
          state_d.bankNib = aluRes;
        end
      end
    end

    // Software writes take priority over the ALU update
    if (regWrStrobe) begin
      // Pointer bank nibble
      if (sfw_hit(regAddr, SFW_ADDR_BANK)) begin
        state_d.bankNib = regWrData;
      end
      // Row nibble with the decimal flag in bit 0
      if (sfw_hit(regAddr, SFW_ADDR_ROW)) begin
        state_d.rowNib = regWrData;
      end
      // Flag nibble as a whole
      if (sfw_hit(regAddr, SFW_ADDR_FLAGS)) begin
        state_d.flags = regWrData;
      end
    end

    // Read data valid the cycle after the strobe
    // Unmapped addresses and idle cycles read as zero
    state_d.rdData = SFW_RST_DATA;
    if (regRdStrobe) begin
      if (sfw_hit(regAddr, SFW_ADDR_BANK)) begin
        state_d.rdData = state_q.bankNib;
      end else if (sfw_hit(regAddr, SFW_ADDR_ROW)) begin
        state_d.rdData = state_q.rowNib;
      end else if (sfw_hit(regAddr, SFW_ADDR_FLAGS)) begin
        state_d.rdData = state_q.flags;
      end
    end
  end

  // State register; pointer, flags and addresses hold while no step or write is issued
  // Reset branch loads constants only
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      // Pointer nibbles
      state_q.bankNib <= SFW_RST_BANK;
      state_q.rowNib  <= SFW_RST_ROW;
      // Flag nibble
      state_q.flags   <= SFW_RST_FLAGS;
      // Bus and address flops
      state_q.rdData  <= SFW_RST_DATA;
      state_q.wrkAddr <= SFW_RST_ADDR;
      state_q.effAddr <= SFW_RST_ADDR;
      // Write-back flops
      state_q.resWr   <= 1'b0;
      state_q.resAddr <= SFW_RST_ADDR;
      state_q.resData <= SFW_RST_DATA;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs straight from the state flops
  // Register bus read data
  assign regRdData         = state_q.rdData;

  // Flag word and its single-bit views
  assign flagWord          = {state_q.flags,
                              state_q.rowNib[SFW_BIT_DEC]};
  assign decimalMode       = state_q.rowNib[SFW_BIT_DEC];
  assign indexModifyEnable = state_q.flags[SFW_BIT_IXE];

  // Working and operand addresses
  assign wrkAddr           = state_q.wrkAddr;
  assign effMemAddr        = state_q.effAddr;

  // Write-back request
  assign resultWrite       = state_q.resWr;
  assign resultAddr        = state_q.resAddr;
  assign resultData        = state_q.resData;

endmodule

//--- sim/sfw_monitor.sv
`timescale 1ns/100ps
module sfw_monitor
  import sfw_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic [6:0]  regAddr,
  input wire logic [3:0]  regWrData,
  input wire logic        regWrStrobe,
  input wire logic        regRdStrobe,
  input wire logic [3:0]  regRdData,
  input wire logic        instrEn,
  input wire sfw_op_t     aluOp,
  input wire logic [3:0]  opColumn,
  input wire logic [10:0] memAddr,
  input wire logic [10:0] indexValue,
  input wire logic [4:0]  flagWord,
  input wire logic        decimalMode,
  input wire logic        indexModifyEnable,
  input wire logic [10:0] wrkAddr,
  input wire logic [10:0] effMemAddr,
  input wire logic        resultWrite
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire wrF = regWrStrobe && regAddr == SFW_ADDR_FLAGS;
  wire wrR = regWrStrobe && regAddr == SFW_ADDR_ROW;
  // Flag word against its sources
  property p_dec; decimalMode == flagWord[0]; endproperty
  a_dec: assert property (p_dec) else $error("dec bit");
  property p_ixe; indexModifyEnable == flagWord[1]; endproperty
  a_ixe: assert property (p_ixe) else $error("ixe bit");
  property p_fw; wrF |=> flagWord[4:1] == $past(regWrData); endproperty
  a_fw: assert property (p_fw) else $error("flag write");
  property p_rw; wrR |=> decimalMode == $past(regWrData[0]); endproperty
  a_rw: assert property (p_rw) else $error("row write");
  // Operand addressing
  property p_ix0;
    instrEn && !indexModifyEnable |=> effMemAddr == $past(memAddr);
  endproperty
  a_ix0: assert property (p_ix0) else $error("no index");
  property p_ix1; instrEn && indexModifyEnable |=>
    effMemAddr == $past(memAddr) + $past(indexValue); endproperty
  a_ix1: assert property (p_ix1) else $error("index");
  property p_col; instrEn |=> wrkAddr[3:0] == $past(opColumn); endproperty
  a_col: assert property (p_col) else $error("column");
  // Write-back and retention
  property p_ns; instrEn && flagWord[4] &&
    aluOp inside {[SFW_OP_ADD:SFW_OP_SUBC]} |=> !resultWrite; endproperty
  a_ns: assert property (p_ns) else $error("stored");
  property p_hold; !instrEn && !regWrStrobe |=> $stable(flagWord); endproperty
  a_hold: assert property (p_hold) else $error("flags moved");
  property p_src; resultWrite |-> $past(instrEn); endproperty
  a_src: assert property (p_src) else $error("stray write");
  property p_rd0; !regRdStrobe |=> regRdData == 4'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("read data");
endmodule
bind sfw_flags_core sfw_monitor u_mon (.*);

//--- sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import sfw_pkg::*;
  logic        sys_clk = 1'b0, reset_n = 1'b0, rdSeen = 1'b0;
  logic [6:0]  regAddr = '0;
  logic [3:0]  regWrData = '0, memNibble = '0, wrkNibble = '0;
  logic [3:0]  opColumn = '0, regRdData, resultData, m, w, c;
  logic        regWrStrobe = 1'b0, regRdStrobe = 1'b0;
  logic        instrEn = 1'b0, destIsWrk = 1'b0;
  sfw_op_t     aluOp = SFW_OP_NONE;
  logic [10:0] memAddr = '0, indexValue = '0;
  logic [10:0] wrkAddr, effMemAddr, resultAddr;
  logic [4:0]  flagWord, s;
  logic        decimalMode, indexModifyEnable, resultWrite;
  logic [14:0] wbQ[$];
  logic [3:0]  rdQ[$];
  int          mismatches = 0, checks = 0, cyc = 0, seed = 32'h5E9D;
  sfw_flags_core uut (.*);
  initial forever #2.5 sys_clk = ~sys_clk;
  task automatic chk(string n, logic [14:0] e, logic [14:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic reg_cyc(logic rd, logic [6:0] a, logic [3:0] d);
    @(posedge sys_clk);
    regRdStrobe <= rd;
    regWrStrobe <= !rd;
    regAddr <= a;
    regWrData <= d;
    if (rd) rdQ.push_back(d);
    @(posedge sys_clk);
    regRdStrobe <= 1'b0;
    regWrStrobe <= 1'b0;
  endtask
  // Address step, then the operation step
  task automatic op(sfw_op_t o, logic [3:0] mm, ww, cc, logic d);
    @(posedge sys_clk);
    instrEn <= 1'b1;
    memNibble <= mm;
    wrkNibble <= ww;
    opColumn <= cc;
    destIsWrk <= d;
    @(posedge sys_clk);
    aluOp <= o;
    @(posedge sys_clk);
    instrEn <= 1'b0;
    aluOp <= SFW_OP_NONE;
    @(negedge sys_clk);
  endtask
  // Result watcher
  always @(posedge sys_clk) rdSeen <= regRdStrobe;
  always @(negedge sys_clk) begin
    if (rdSeen) chk("rdData", rdQ.pop_front(), regRdData);
    if (resultWrite) chk("writeBack", wbQ.size() ? wbQ.pop_front() :
      15'h7FFF, {resultAddr, resultData});
    cyc++;
    if (cyc > 4000) begin
      mismatches++;
      results;
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    reg_cyc(1, SFW_ADDR_BANK, 4'h0);
    reg_cyc(1, SFW_ADDR_ROW, 4'h0);
    reg_cyc(1, SFW_ADDR_FLAGS, 4'h0);
    reg_cyc(0, SFW_ADDR_BANK, 4'hA);
    reg_cyc(0, SFW_ADDR_ROW, 4'h5);
    reg_cyc(1, SFW_ADDR_ROW, 4'h5);
    reg_cyc(1, 7'h10, 4'h0);
    wbQ.push_back({11'h523, 4'h2});
    op(SFW_OP_ADD, 4'h7, 4'h5, 4'h3, 1'b1);
    chk("wrkAddr", 11'h523, wrkAddr);
    chk("flags", 5'h09, flagWord);
    reg_cyc(0, SFW_ADDR_ROW, 4'h4);
    repeat (8) begin
      m = 4'($random(seed));
      w = 4'($random(seed));
      c = 4'($random(seed));
      s = w + m;
      wbQ.push_back({7'h52, c, s[3:0]});
      op(SFW_OP_ADD, m, w, c, 1'b1);
      chk("flags", {1'b0, s[4], s[3:0] == 4'h0, 2'b0}, flagWord);
    end
    wbQ.push_back({11'h523, 4'hE});
    op(SFW_OP_SUB, 4'h5, 4'h3, 4'h3, 1'b1);
    chk("flags", 5'h08, flagWord);
    // Chained forms take the carry in; transfer keeps flags
    wbQ.push_back({11'h523, 4'h4});
    op(SFW_OP_ADDC, 4'h1, 4'h2, 4'h3, 1'b1);
    chk("flags", 5'h00, flagWord);
    wbQ.push_back({11'h523, 4'h0});
    op(SFW_OP_SUBC, 4'h5, 4'h5, 4'h3, 1'b1);
    chk("flags", 5'h04, flagWord);
    wbQ.push_back({11'h523, 4'h6});
    op(SFW_OP_PASS, 4'h6, 4'h2, 4'h3, 1'b1);
    chk("flags", 5'h04, flagWord);
    reg_cyc(0, SFW_ADDR_FLAGS, 4'hA);
    op(SFW_OP_ADD, 4'h8, 4'h8, 4'h3, 1'b1);
    chk("flags", 5'h1C, flagWord);
    op(SFW_OP_ADD, 4'h1, 4'h1, 4'h3, 1'b1);
    chk("flags", 5'h10, flagWord);
    reg_cyc(0, SFW_ADDR_FLAGS, 4'h4);
    wbQ.push_back({11'h523, 4'h9});
    op(SFW_OP_ROTATE_RIGHT_THROUGH_CARRY_OP, 4'h0, 4'h3, 4'h3, 1'b1);
    chk("flags", 5'h08, flagWord);
    reg_cyc(0, SFW_ADDR_FLAGS, 4'h1);
    memAddr <= 11'h123;
    indexValue <= 11'h005;
    wbQ.push_back({11'h128, 4'h3});
    op(SFW_OP_ADD, 4'h1, 4'h2, 4'h3, 1'b0);
    chk("effMemAddr", 11'h128, effMemAddr);
    reg_cyc(0, SFW_ADDR_FLAGS, 4'h0);
    memAddr <= 11'h07F;
    wbQ.push_back({11'h07F, 4'h0});
    op(SFW_OP_ADD, 4'h8, 4'h8, 4'h3, 1'b0);
    reg_cyc(1, SFW_ADDR_FLAGS, 4'h0);
    repeat (2) @(negedge sys_clk);
    chk("pending", 15'h0, 15'(wbQ.size()));
    results;
  end
endmodule
